// ==== verilog/intc_pkg.sv ====
// Behaviour
// RULE_01: Twelve sources, each gated by own enable.
// RULE_02: Global enable clear blocks every source.
// RULE_03: Two priority bits give four levels.
// RULE_04: Only strictly higher level pre-empts active service.
// RULE_05: Highest level service is never pre-empted.
// RULE_06: Higher level wins among simultaneous requests.
// RULE_07: Equal level resolved by fixed arbitration ranking.
// RULE_08: Each source vectors to fixed code address.
// RULE_09: Only listed sources wake from power-down.
// RULE_10: Mode bit selects low level or edge.
// RULE_11: Edge flag set on high then low sample.
// RULE_12: Pins sampled once per six-clock machine cycle.
// RULE_13: Source holds high, then low, one cycle each.
// RULE_14: Edge flag cleared by hardware on vectoring.
// RULE_15: Level flag follows pin, retriggers if low.
// RULE_16: Level source holds request until interrupt taken.
// RULE_17: Enabled external request wakes idle or power-down. The code has no idle input and wakes from power-down only.
// RULE_18: In-service levels tracked, released on return.
package intc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SRC     = 12;           // Source count
  localparam int NUM_LVL     = 4;            // Priority levels
  localparam int MC_CLOCKS   = 6;            // CPU clocks per machine cycle
  localparam logic [2:0] MC_LAST = 3'h5;     // Last phase of machine cycle

  // ****************************************
  // Source indices (vector order)
  // ****************************************
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER  = 4;
  localparam int SRC_BOD  = 5;
  localparam int SRC_I2C  = 6;
  localparam int SRC_KBD  = 7;
  localparam int SRC_CMP2 = 8;
  localparam int SRC_WDT  = 9;
  localparam int SRC_CMP1 = 10;
  localparam int SRC_TMRI = 11;

  // Arbitration order, best first, as source indices
  localparam logic [3:0] RANK_ORDER [NUM_SRC] = '{
    4'h0, 4'h5, 4'h9, 4'h1, 4'h6, 4'h2, 4'h7, 4'hA, 4'h3, 4'h8, 4'h4, 4'hB};

  // Vector addresses per source
  localparam logic [15:0] VECTOR_ADDR [NUM_SRC] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
    16'h0033, 16'h003B, 16'h0043, 16'h0053, 16'h0063, 16'h0073};

  // Power-down wake capable sources
  localparam logic [11:0] WAKE_MASK = 12'h7A5;

  // Enable bit positions in the two enable registers
  localparam int GLOBAL_EN_BIT = 7;
  localparam int EN_POS [NUM_SRC] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 6, 5, 7};
  localparam logic [11:0] EN_IN_B = 12'hDC0;   // Sources held in register b

  // Reset values
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [3:0]  ACTIVE_RESET = 4'h0;
  localparam logic [2:0]  PHASE_RESET  = 3'h0;

endpackage

// ==== verilog/ext_int_detect.sv ====
module ext_int_detect (
  input  wire logic ref_clk,      // CPU clock
  input  wire logic rstn,         // Async reset, active low
  input  wire logic pin_n,        // External pin, active low
  input  wire logic edge_select,  // 1 edge, 0 level
  input  wire logic sample_en,    // Machine cycle sample strobe
  input  wire logic vector_ack,   // Service routine vectored
  output logic      request_flag, // Request flag
  output logic      pin_level     // Synchronised level
);

  // ****************************************
  // Synchroniser and sample state
  // ****************************************
  logic sync1_reg, sync1_next;    // First stage
  logic sync2_reg, sync2_next;    // Second stage
  logic samp_reg,  samp_next;     // Previous machine-cycle sample
  logic flag_reg,  flag_next;     // Request flag

  // Next values
  always_comb begin
    sync1_next = pin_n;
    sync2_next = sync1_reg;
    samp_next  = samp_reg;
    flag_next  = flag_reg;
    if (sample_en) begin
      samp_next = sync2_reg;  // RULE_12
    end
    if (edge_select) begin
      // Edge mode: ack clears, new fall wins over clear
      if (vector_ack) begin
        flag_next = 1'b0;  // RULE_14
      end
      if (sample_en && samp_reg && !sync2_reg) begin
        flag_next = 1'b1;  // RULE_11
      end
    end else if (sample_en) begin
      flag_next = !sync2_reg;  // RULE_15
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      samp_reg  <= 1'b1;
      flag_reg  <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      samp_reg  <= samp_next;
      flag_reg  <= flag_next;
    end
  end

  assign request_flag = flag_reg;
  assign pin_level    = sync2_reg;

endmodule // ext_int_detect

// ==== verilog/four_level_interrupt_controller.sv ====
module four_level_interrupt_controller (
  input  wire logic        ref_clk,                // CPU clock, 40 MHz
  input  wire logic        rstn,                   // Async reset, active low
  input  wire logic [7:0]  int_enable_reg_a,       // Enable register a, bit 7 global
  input  wire logic [7:0]  int_enable_reg_b,       // Enable register b
  input  wire logic [7:0]  prio_low_reg_a,         // Priority low bits a
  input  wire logic [7:0]  prio_high_reg_a,        // Priority high bits a
  input  wire logic [7:0]  prio_low_reg_b,         // Priority low bits b
  input  wire logic [7:0]  prio_high_reg_b,        // Priority high bits b
  input  wire logic        ext0_edge_select,       // Ext 0 mode, 1 edge
  input  wire logic        ext1_edge_select,       // Ext 1 mode, 1 edge
  input  wire logic        ext0_int_pin_n,         // Ext 0 pin, active low
  input  wire logic        ext1_int_pin_n,         // Ext 1 pin, active low
  input  wire logic        timer0_overflow_flag,   // Timer 0 request
  input  wire logic        timer1_overflow_flag,   // Timer 1 request
  input  wire logic        serial_tx_flag,         // Serial transmit
  input  wire logic        serial_rx_flag,         // Serial receive
  input  wire logic        brownout_flag,          // Brownout request
  input  wire logic        i2c_attention_flag,     // I2C request
  input  wire logic        keypad_flag,            // Keypad request
  input  wire logic        comparator1_flag,       // Comparator 1 request
  input  wire logic        comparator2_flag,       // Comparator 2 request
  input  wire logic        watchdog_overflow_flag, // Watchdog request
  input  wire logic        timer_i_flag,           // Timer I request
  input  wire logic        cpu_ack,                // Core takes vector, pulse
  input  wire logic        cpu_return,             // Service return, pulse
  input  wire logic        cpu_power_down,         // Core in power-down
  output logic             int_request,            // Request to core
  output logic [15:0]      int_vector,             // Vector address
  output logic [3:0]       int_source,             // Winning source index
  output logic [1:0]       int_level,              // Winning level
  output logic             wake_up,                // Wake request, level
  output logic             ext0_request_flag,      // Ext 0 flag view
  output logic             ext1_request_flag,      // Ext 1 flag view
  output logic [3:0]       active_levels           // In-service levels
);

  // ****************************************
  // Machine cycle phase
  // ****************************************
  logic [2:0] phase_reg, phase_next;  // Clock within machine cycle
  logic       sample_en;              // Once per machine cycle

  // Pins are looked at once per
  // machine cycle only, so a pulse
  // shorter than six clocks can be
  // missed. The counter runs free
  // from reset; the first strobe
  // falls on the sixth clock.
  // Phase counter next value
  always_comb begin
    if (phase_reg == intc_pkg::MC_LAST) begin
      phase_next = intc_pkg::PHASE_RESET;
    end else begin
      phase_next = phase_reg + 3'h1;
    end
  end

  // Phase 0 follows reset
  // Phase counter register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= intc_pkg::PHASE_RESET;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign sample_en = (phase_reg == intc_pkg::MC_LAST);  // RULE_12

  // ****************************************
  // External inputs
  // ****************************************
  // Index 0 is external 0 and
  // index 1 external 1 below
  logic [1:0] ext_flag;      // Detector flags
  logic [1:0] ext_pin_lvl;   // Synchronised pins
  logic [1:0] ext_ack;       // Vector acknowledge per input
  logic [1:0] ext_mode;      // Edge selects
  logic [1:0] ext_pins;      // Raw pins
  logic       ack_take;      // Vector taken this cycle

  assign ext_mode = {ext1_edge_select, ext0_edge_select};  // RULE_10
  assign ext_pins = {ext1_int_pin_n, ext0_int_pin_n};

  // Each pin passes two flops before
  // it is sampled, so a change needs
  // up to eight clocks to reach its
  // flag. An edge flag is cleared
  // only when the core takes the
  // vector of that very source.
  // One detector per external input
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ext
      ext_int_detect u_det (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .pin_n        (ext_pins[g]),
        .edge_select  (ext_mode[g]),
        .sample_en    (sample_en),
        .vector_ack   (ext_ack[g]),
        .request_flag (ext_flag[g]),
        .pin_level    (ext_pin_lvl[g])
      );
    end
  endgenerate

  // ****************************************
  // Source gathering
  // ****************************************
  // Bit n of each vector is source n,
  // in vector address order
  logic [11:0] src_raw;     // Raw requests
  logic [11:0] src_en;      // Individual enables
  logic [11:0] src_req;     // Gated requests
  logic [1:0]  src_lvl [intc_pkg::NUM_SRC];  // Per-source level
  logic        global_en;   // Global enable

  // Both serial flags share one
  // source; either one requests
  // Raw request vector in source order
  always_comb begin
    src_raw = 12'h000;
    src_raw[intc_pkg::SRC_EXT0] = ext_flag[0];
    src_raw[intc_pkg::SRC_TMR0] = timer0_overflow_flag;
    src_raw[intc_pkg::SRC_EXT1] = ext_flag[1];
    src_raw[intc_pkg::SRC_TMR1] = timer1_overflow_flag;
    src_raw[intc_pkg::SRC_SER]  = serial_tx_flag | serial_rx_flag;
    src_raw[intc_pkg::SRC_BOD]  = brownout_flag;
    src_raw[intc_pkg::SRC_I2C]  = i2c_attention_flag;
    src_raw[intc_pkg::SRC_KBD]  = keypad_flag;
    src_raw[intc_pkg::SRC_CMP2] = comparator2_flag;
    src_raw[intc_pkg::SRC_WDT]  = watchdog_overflow_flag;
    src_raw[intc_pkg::SRC_CMP1] = comparator1_flag;
    src_raw[intc_pkg::SRC_TMRI] = timer_i_flag;
  end

  // Global enable is bit 7 of register a
  assign global_en = int_enable_reg_a[intc_pkg::GLOBAL_EN_BIT];

  // Enable and priority bits share a
  // bit position in register a or b;
  // the package tables pick which.
  // The global bit masks every source.
  // Per-source enable and level lookup
  generate
    for (g = 0; g < intc_pkg::NUM_SRC; g++) begin : g_src
      if (intc_pkg::EN_IN_B[g]) begin : g_b
        assign src_en[g]  = int_enable_reg_b[intc_pkg::EN_POS[g]];  // RULE_01
        assign src_lvl[g] = {prio_high_reg_b[intc_pkg::EN_POS[g]],
                             prio_low_reg_b[intc_pkg::EN_POS[g]]};  // RULE_03
      end else begin : g_a
        assign src_en[g]  = int_enable_reg_a[intc_pkg::EN_POS[g]];  // RULE_01
        assign src_lvl[g] = {prio_high_reg_a[intc_pkg::EN_POS[g]],
                             prio_low_reg_a[intc_pkg::EN_POS[g]]};  // RULE_03
      end
      assign src_req[g] = src_raw[g] & src_en[g] & global_en;  // RULE_02
    end
  endgenerate

  // ****************************************
  // Arbitration
  // ****************************************
  // Arbitration is combinational and
  // settles within one clock
  logic [3:0]  active_reg, active_next;  // In-service level bits
  logic [1:0]  cur_lvl;                  // Highest level in service
  logic        any_active;               // Some level in service
  logic        win_found;                // A request can be dispatched
  logic [3:0]  win_src;                  // Winning source
  logic [1:0]  win_lvl;                  // Winning level

  // Nested service sets one bit per
  // level; the top set bit is running
  // Highest level currently in service
  always_comb begin
    any_active = |active_reg;
    cur_lvl    = 2'h0;
    for (int l = 0; l < intc_pkg::NUM_LVL; l++) begin
      if (active_reg[l]) begin
        cur_lvl = 2'(l);
      end
    end
  end

  // Levels scanned top down, sources
  // in rank order inside a level.
  // First hit wins, so a lower level
  // never shadows a higher one. The
  // hit is masked afterwards if it
  // cannot pre-empt the running level.
  // Pick highest level, then best rank among that level
  always_comb begin
    logic [3:0] s;
    s         = 4'h0;
    win_found = 1'b0;
    win_src   = 4'h0;
    win_lvl   = 2'h0;
    for (int l = intc_pkg::NUM_LVL - 1; l >= 0; l--) begin
      for (int r = 0; r < intc_pkg::NUM_SRC; r++) begin
        s = intc_pkg::RANK_ORDER[r];
        if (!win_found && src_req[s] && src_lvl[s] == 2'(l)) begin
          win_found = 1'b1;  // RULE_06
          win_src   = s;     // RULE_07
          win_lvl   = 2'(l);
        end
      end
    end
    // Only strictly higher level may pre-empt; top level never beaten
    if (any_active && win_lvl <= cur_lvl) begin
      win_found = 1'b0;  // RULE_04 RULE_05
    end
  end

  // ****************************************
  // Dispatch and in-service tracking
  // ****************************************
  // State the core sees, and state
  // that remembers nested service
  logic        req_reg, req_next;      // Request to core
  logic [15:0] vec_reg, vec_next;      // Vector output
  logic [3:0]  srcq_reg, srcq_next;    // Source output
  logic [1:0]  lvlq_reg, lvlq_next;    // Level output
  logic        wake_reg, wake_next;    // Wake output
  logic [1:0]  ef_reg, ef_next;        // External flag view

  // An ack counts only while an offer
  // stands; a stray pulse is ignored
  assign ack_take = cpu_ack & req_reg;
  assign ext_ack[0] = ack_take && (srcq_reg == 4'(intc_pkg::SRC_EXT0));  // RULE_14
  assign ext_ack[1] = ack_take && (srcq_reg == 4'(intc_pkg::SRC_EXT1));  // RULE_14

  // Next values for dispatch state
  always_comb begin
    active_next = active_reg;
    // Return releases the highest level in service
    if (cpu_return && any_active) begin
      active_next[cur_lvl] = 1'b0;  // RULE_18
    end
    // Taken vector marks its level in service
    if (ack_take) begin
      active_next[lvlq_reg] = 1'b1;  // RULE_18
    end
    // Offer drops for a cycle after a
    // take or return, so level bits
    // settle before the next winner
    // is shown to the core
    // Offer recomputed each cycle, dropped once taken
    req_next  = win_found && !ack_take && !cpu_return;
    vec_next  = intc_pkg::VECTOR_ADDR[win_src];  // RULE_08
    srcq_next = win_src;
    lvlq_next = win_lvl;
    if (ack_take || cpu_return) begin
      vec_next  = vec_reg;
      srcq_next = srcq_reg;
      lvlq_next = lvlq_reg;
    end
    // Wake is a level; it falls once
    // the core leaves power-down
    // Wake on any enabled wake-capable request while powered down
    wake_next = cpu_power_down && |(src_req & intc_pkg::WAKE_MASK);  // RULE_09 RULE_17
    ef_next   = ext_flag;
  end

  // Vector, source and level hold
  // across a take, so the core reads
  // a steady value while it vectors
  // Dispatch registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_reg <= intc_pkg::ACTIVE_RESET;
      req_reg    <= 1'b0;
      vec_reg    <= 16'h0000;
      srcq_reg   <= 4'h0;
      lvlq_reg   <= 2'h0;
      wake_reg   <= 1'b0;
      ef_reg     <= 2'h0;
    end else begin
      active_reg <= active_next;
      req_reg    <= req_next;
      vec_reg    <= vec_next;
      srcq_reg   <= srcq_next;
      lvlq_reg   <= lvlq_next;
      wake_reg   <= wake_next;
      ef_reg     <= ef_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop, so the
  // core never sees a glitch
  assign int_request       = req_reg;
  assign int_vector        = vec_reg;
  assign int_source        = srcq_reg;
  assign int_level         = lvlq_reg;
  assign wake_up           = wake_reg;
  assign ext0_request_flag = ef_reg[0];
  assign ext1_request_flag = ef_reg[1];
  assign active_levels     = active_reg;

endmodule // four_level_interrupt_controller

// ==== sim/intc_props.sv ====
module intc_props (
  input wire logic        ref_clk,           // CPU clock
  input wire logic        rstn,              // Reset, active low
  input wire logic [7:0]  int_enable_reg_a,  // Enables a
  input wire logic [7:0]  int_enable_reg_b,  // Enables b
  input wire logic [7:0]  prio_low_reg_a,    // Priority low a
  input wire logic [7:0]  prio_high_reg_a,   // Priority high a
  input wire logic [7:0]  prio_low_reg_b,    // Priority low b
  input wire logic [7:0]  prio_high_reg_b,   // Priority high b
  input wire logic        ext0_edge_select,  // Ext 0 mode
  input wire logic        cpu_ack,           // Vector taken
  input wire logic        cpu_return,        // Routine return
  input wire logic        int_request,       // Offer
  input wire logic [15:0] int_vector,        // Offered vector
  input wire logic [3:0]  int_source,        // Offered source
  input wire logic [1:0]  int_level,         // Offered level
  input wire logic        ext0_request_flag, // Ext 0 flag
  input wire logic [3:0]  active_levels      // In-service levels
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Helper logic
  // ****************************************
  localparam int POS [12] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 6, 5, 7}; // Enable bit per source
  localparam logic [11:0] IN_B = 12'hDC0;   // Sources in register b
  logic [3:0]  top_bit;  // Highest in-service level
  logic [3:0]  rel_lvls; // Levels left after a return
  logic [15:0] exp_vec;  // Vector of offered source
  logic [1:0]  src_lvl;  // Level of offered source
  logic        src_en;   // Enable of offered source
  logic [47:0] cfg;      // All enables and priorities
  logic [2:0]  p;        // Enable bit of source

  // Decode offered source and in-service state
  always_comb begin
    top_bit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (active_levels[i]) begin
        top_bit = 4'h1 << i;
      end
    end
    rel_lvls = active_levels & ~top_bit;
    exp_vec = (int_source < 4'h9) ? 16'h0003 + {9'h000, int_source, 3'h0}
                                  : 16'h0053 + {8'h00, int_source - 4'h9, 4'h0};
    cfg = {int_enable_reg_a, int_enable_reg_b, prio_low_reg_a, prio_high_reg_a,
           prio_low_reg_b, prio_high_reg_b};
    p = 3'(POS[int_source]);
    src_en = IN_B[int_source] ? int_enable_reg_b[p] : int_enable_reg_a[p];
    src_lvl = IN_B[int_source] ? {prio_high_reg_b[p], prio_low_reg_b[p]}
                               : {prio_high_reg_a[p], prio_low_reg_a[p]};
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  glob_off_a: assert property (!$past(int_enable_reg_a[7]) |-> !int_request)
    else $error("offer while globally disabled");
  src_en_a: assert property (int_request && $stable(cfg) |-> src_en)
    else $error("offer from disabled source");
  lvl_map_a: assert property (int_request && $stable(cfg) |-> int_level == src_lvl)
    else $error("offered level differs from priority bits");
  vec_map_a: assert property (int_request |-> int_vector == exp_vec)
    else $error("wrong vector for source");
  lvl_preempt_a: assert property (int_request |-> (active_levels >> int_level) == 4'h0)
    else $error("offer not above active level");
  top_hold_a: assert property (active_levels[3] |-> !int_request)
    else $error("top level service pre-empted");
  ack_take_a: assert property (int_request && cpu_ack |=>
    !int_request && active_levels[$past(int_level)])
    else $error("ack not recorded");
  ret_free_a: assert property (cpu_return && !cpu_ack |=> active_levels == $past(rel_lvls))
    else $error("return did not release top level");
  edge_clr_a: assert property (int_request && cpu_ack && int_source == 4'h0 &&
    ext0_edge_select |-> ##2 !ext0_request_flag)
    else $error("edge flag not cleared on vectoring");
endmodule // intc_props

bind four_level_interrupt_controller intc_props u_props (.ref_clk, .rstn, .int_enable_reg_a,
  .int_enable_reg_b, .prio_low_reg_a, .prio_high_reg_a, .prio_low_reg_b, .prio_high_reg_b,
  .ext0_edge_select, .cpu_ack, .cpu_return, .int_request, .int_vector, .int_source,
  .int_level, .ext0_request_flag, .active_levels);

// ==== sim/cpu_model.sv ====
module cpu_model (
  input  wire logic       ref_clk,     // CPU clock
  input  wire logic       rstn,        // Reset, active low
  input  wire logic       int_request, // Offer from controller
  input  wire logic       ack_en,      // Allow taking offers
  input  wire logic [3:0] ack_wait,    // Cycles before taking
  input  wire logic       ret_cmd,     // Finish routine
  output logic            cpu_ack,     // Vector taken, pulse
  output logic            cpu_return   // Return, pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] age_reg; // Cycles the offer has waited

  // Takes an offer after a set delay, one pulse per offer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack <= 1'b0;
      cpu_return <= 1'b0;
      age_reg <= 4'h0;
    end else begin
      cpu_return <= ret_cmd;
      if (cpu_ack || !int_request || !ack_en) begin
        cpu_ack <= 1'b0;
        age_reg <= 4'h0;
      end else if (age_reg == ack_wait) begin
        cpu_ack <= 1'b1;
      end else begin
        age_reg <= age_reg + 4'h1;
      end
    end
  end
endmodule // cpu_model

// ==== sim/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
  localparam logic [11:0] WAKE = 12'h7A5; // Sources able to wake
  logic        ref_clk, rstn, sel0, sel1, pin0_n, pin1_n, pdn, ack_en, ret_cmd;
  logic [7:0]  en_a, en_b, pl_a, ph_a, pl_b, ph_b;
  logic [11:0] rq;           // Source requests, bit 0 serial receive
  logic [3:0]  ack_wait, int_source, active_levels;
  logic        cpu_ack, cpu_return, int_request, wake_up, ext0_request_flag, ext1_request_flag;
  logic [15:0] int_vector;
  logic [1:0]  int_level;
  int          errors, samples_checked, cycles;

  four_level_interrupt_controller u_dut (.ref_clk, .rstn, .int_enable_reg_a(en_a),
    .int_enable_reg_b(en_b), .prio_low_reg_a(pl_a), .prio_high_reg_a(ph_a),
    .prio_low_reg_b(pl_b), .prio_high_reg_b(ph_b), .ext0_edge_select(sel0),
    .ext1_edge_select(sel1), .ext0_int_pin_n(pin0_n), .ext1_int_pin_n(pin1_n),
    .timer0_overflow_flag(rq[1]), .timer1_overflow_flag(rq[3]), .serial_tx_flag(rq[4]),
    .serial_rx_flag(rq[0]), .brownout_flag(rq[5]), .i2c_attention_flag(rq[6]),
    .keypad_flag(rq[7]), .comparator1_flag(rq[10]), .comparator2_flag(rq[8]),
    .watchdog_overflow_flag(rq[9]), .timer_i_flag(rq[11]), .cpu_ack, .cpu_return,
    .cpu_power_down(pdn), .int_request, .int_vector, .int_source, .int_level, .wake_up,
    .ext0_request_flag, .ext1_request_flag, .active_levels);
  cpu_model u_cpu (.ref_clk, .rstn, .int_request, .ack_en, .ack_wait, .ret_cmd, .cpu_ack,
    .cpu_return);

  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Raise or drop one source, ext pins active low
  task automatic raise(input int s, input logic v);
    @(posedge ref_clk);
    if (s == 0) pin0_n <= !v;
    else if (s == 2) pin1_n <= !v;
    else rq[s] <= v;
  endtask
  task automatic wreq();
    for (int n = 0; n < 40 && int_request !== 1'b1; n++) @(negedge ref_clk);
    `CHK(int_request, 1'b1)
  endtask
  task automatic none();
    repeat (12) @(negedge ref_clk);
    `CHK(int_request, 1'b0)
  endtask
  // Let the core take the offer, expecting source s
  task automatic serve(input int s);
    wreq();
    `CHK(int_source, 4'(s))
    @(posedge ref_clk);
    ack_en <= 1'b1;
    for (int n = 0; n < 20 && cpu_ack !== 1'b1; n++) @(negedge ref_clk);
    @(posedge ref_clk);
    ack_en <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic ret(input int gap);
    repeat (gap) @(posedge ref_clk);
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    ret_cmd <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_vec();
    for (int s = 0; s < 12; s++) begin
      raise(s, 1'b1);
      ack_wait <= 4'(s);
      wreq();
      if (s == 2) `CHK(ext1_request_flag, 1'b1)
      `CHK(int_vector, (s < 9) ? 16'h0003 + 16'(8 * s) : 16'h0053 + 16'(16 * (s - 9)))
      serve(s);
      raise(s, 1'b0);
      ret(12);
    end
  endtask
  task automatic t_rank();
    int order [12] = '{0, 5, 9, 1, 6, 2, 7, 10, 3, 8, 4, 11};
    @(posedge ref_clk);
    ack_wait <= 4'h0;
    rq <= 12'hFFA;
    {pin0_n, pin1_n} <= 2'h0;
    repeat (12) @(posedge ref_clk); // Let both pin flags rise
    foreach (order[i]) begin
      serve(order[i]);
      raise(order[i], 1'b0);
      ret(12);
    end
  endtask
  task automatic t_prio();
    @(posedge ref_clk);
    {ph_a[3], pl_a[3], pl_a[1]} <= 3'h7;
    {rq[3], rq[5]} <= 2'h3;
    serve(3);
    `CHK(active_levels, 4'h8)
    raise(1, 1'b1);
    none();
    raise(3, 1'b0);
    ret(1);
    serve(1);
    none();
    raise(3, 1'b1);
    serve(3);
    `CHK(active_levels, 4'hA)
    raise(3, 1'b0);
    ret(1);
    `CHK(active_levels, 4'h2)
    raise(1, 1'b0);
    ret(1);
    serve(5);
    raise(5, 1'b0);
    ret(1);
    @(posedge ref_clk);
    {ph_a, pl_a} <= 16'h0000;
  endtask
  task automatic t_edge();
    @(posedge ref_clk);
    sel0 <= 1'b1;
    repeat (12) @(posedge ref_clk);
    pin0_n <= 1'b0;
    wreq();
    `CHK(ext0_request_flag, 1'b1)
    serve(0);
    repeat (3) @(negedge ref_clk);
    `CHK(ext0_request_flag, 1'b0)
    ret(1);
    none();
    @(posedge ref_clk);
    sel0 <= 1'b0;
    serve(0);
    ret(1);
    serve(0);
    raise(0, 1'b0);
    ret(12);
    @(posedge ref_clk);
    sel1 <= 1'b1;
    repeat (12) @(posedge ref_clk);
    pin1_n <= 1'b0;
    serve(2);
    ret(1);
    none();
    raise(2, 1'b0);
    repeat (12) @(posedge ref_clk);
    sel1 <= 1'b0;
  endtask
  task automatic t_glob();
    @(posedge ref_clk);
    en_a <= 8'h7F;
    rq[0] <= 1'b1;
    none();
    @(posedge ref_clk);
    en_a <= 8'hEF;
    none();
    @(posedge ref_clk);
    en_a <= 8'hFF;
    serve(4);
    @(posedge ref_clk);
    rq[0] <= 1'b0;
    ret(1);
  endtask
  task automatic t_wake();
    for (int s = 0; s < 12; s++) begin
      @(posedge ref_clk);
      pdn <= 1'b1;
      raise(s, 1'b1);
      repeat (12) @(negedge ref_clk);
      `CHK(wake_up, WAKE[s])
      raise(s, 1'b0);
      pdn <= 1'b0;
      repeat (12) @(posedge ref_clk);
    end
  endtask

  // Main sequence
  initial begin
    {rstn, sel0, sel1, pdn, ack_en, ret_cmd} = 6'h00;
    {pin0_n, pin1_n} = 2'h3;
    {en_a, en_b, pl_a, ph_a, pl_b, ph_b} = 48'hFFFF_0000_0000;
    {rq, ack_wait} = 16'h0000;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_vec();
    t_rank();
    t_prio();
    t_edge();
    t_glob();
    t_wake();
    end_sim();
  end
endmodule // tb_top
